// ---- hw/config_prom_cascade_jtag_ctrl.sv ----
`timescale 1ns/1ps
`include "config_prom_defs.svh"

module config_prom_cascade_jtag_ctrl #(
  parameter int ADDR_W = 23,
  parameter int SERIAL_LAST = `CAPACITY_BITS - 1,
  parameter int PARALLEL_LAST = `CAPACITY_BITS / 8 - 1,
  // Identification value is arbitrary
  parameter logic [31:0] IDCODE_VALUE = `IDCODE_DEFAULT,
  parameter logic [31:0] USERCODE_VALUE = `USERCODE_BLANK
) (
  // System
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Configuration port
  input wire logic cclk_i,
  input wire logic ce_n_i,
  input wire logic parallel_mode_i,
  input wire logic oe_reset_i,
  output logic oe_reset_o,
  output logic oe_reset_oe_o,
  output logic [`DATA_W-1:0] data_o,
  output logic [`DATA_W-1:0] data_oe_o,
  output logic chain_enable_out_n_o,
  output logic fpga_reload_request_n_o,
  output logic fpga_reload_request_n_oe_o,
  // Test access port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic read_secure_i,
  // Bitstream source
  input wire logic [`DATA_W-1:0] src_data_i,
  input wire logic src_valid_i,
  output logic src_ready_o,
  output logic fetch_restart_o
);
  localparam logic [ADDR_W-1:0] SER_TC = ADDR_W'(SERIAL_LAST);
  localparam logic [ADDR_W-1:0] PAR_TC = ADDR_W'(PARALLEL_LAST);
  localparam int RLD_W = $clog2(`RELOAD_PULSE_CYC + 1);
  localparam int RST_W = $clog2(`ISP_RESET_CYC + 1);
  // Eight high samples, then the line is released after the rest of the pulse
  localparam int RLD_REST = `RELOAD_PULSE_CYC - 7;

  // ---------------- System clock domain ----------------
  config_prom_pkg::sys_sync_t sync_raw, s1_q, s2_q, s3_q;
  logic isp_tq, highz_tq, clamp_tq, upd_tgl_tq, cfg_tgl_tq;
  logic [`BSR_WIDTH-1:0] bsr_upd_tq;
  logic [`BSR_WIDTH-1:0] bsr_sys_q;
  logic [ADDR_W-1:0] addr_q, tc;
  logic past_tc_q, active, active_q, cclk_rise, step, last_bit, pop;
  logic upd_evt, cfg_evt, isp_rise;
  logic [`DATA_W-1:0] cur_q, buf_data, data_q, data_oe_q;
  logic [2:0] bit_q;
  logic cur_valid_q, buf_valid, chain_n_q, restart_q;
  logic [RLD_W-1:0] rld_cnt_q, rld_cnt_d;
  logic [RST_W-1:0] rst_cnt_q, rst_cnt_d;
  logic reload_oe_q, oe_reset_oe_q, isp_done_q;

  assign sync_raw = '{cclk: cclk_i, ce_n: ce_n_i, oe_reset: oe_reset_i,
                      parallel: parallel_mode_i, in_system_programming: isp_tq, highz: highz_tq,
                      clamp: clamp_tq, upd_tgl: upd_tgl_tq, cfg_tgl: cfg_tgl_tq};

  // Third stage only feeds edge detection of the settled copy
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce_i) begin
      s1_q <= sync_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign active = !s2_q.ce_n && s2_q.oe_reset;
  assign cclk_rise = s2_q.cclk && !s3_q.cclk;
  assign upd_evt = s2_q.upd_tgl ^ s3_q.upd_tgl;
  assign cfg_evt = s2_q.cfg_tgl ^ s3_q.cfg_tgl;
  assign isp_rise = s2_q.in_system_programming && !s3_q.in_system_programming;
  assign tc = s2_q.parallel ? PAR_TC : SER_TC;
  assign step = cclk_rise && active && !past_tc_q && !s2_q.in_system_programming;
  assign last_bit = s2_q.parallel || (bit_q == 3'h7);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      addr_q <= '0;
      past_tc_q <= 1'b0;
    end else if (ce_i) begin
      if (!active) begin
        addr_q <= '0;
        past_tc_q <= 1'b0;
      end else if (step) begin
        if (addr_q == tc) begin
          past_tc_q <= 1'b1;
        end else begin
          addr_q <= addr_q + 1'b1;
        end
      end
    end
  end

  // Source must restart its stream whenever the counter is cleared
  two_entry_buffer #(
    .WIDTH(`DATA_W),
    .DEPTH(2)
  ) u_buf (
    .clk_i(clk_sys_i),
    .resetn_i(resetn_i),
    .en_i(ce_i),
    .flush_i(!active),
    .in_data_i(src_data_i),
    .in_valid_i(src_valid_i),
    .in_ready_o(src_ready_o),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(pop)
  );

  assign pop = active && (!cur_valid_q || (step && last_bit));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cur_q <= '0;
      cur_valid_q <= 1'b0;
      bit_q <= 3'h0;
    end else if (ce_i) begin
      if (!active) begin
        cur_valid_q <= 1'b0;
        bit_q <= 3'h0;
      end else begin
        if (step) begin
          bit_q <= last_bit ? 3'h0 : bit_q + 3'h1;
        end
        if (pop && buf_valid) begin
          cur_q <= buf_data;
          cur_valid_q <= 1'b1;
        end else if (step && last_bit) begin
          cur_valid_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      active_q <= 1'b0;
      restart_q <= 1'b0;
    end else if (ce_i) begin
      active_q <= active;
      restart_q <= active_q && !active;
    end
  end

  // Vector is held in the test clock domain until the next update toggle
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      bsr_sys_q <= '0;
    end else if (ce_i && upd_evt) begin
      bsr_sys_q <= bsr_upd_tq;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      data_q <= '0;
      data_oe_q <= '0;
      chain_n_q <= 1'b1;
    end else if (ce_i) begin
      chain_n_q <= !(active && past_tc_q) || s2_q.in_system_programming;
      if (s2_q.highz) begin
        data_oe_q <= '0;
      end else if (s2_q.clamp) begin
        data_q <= bsr_sys_q[`DATA_W-1:0];
        data_oe_q <= bsr_sys_q[`BSR_WIDTH-1:`DATA_W];
      end else if (s2_q.in_system_programming || !active || past_tc_q) begin
        data_oe_q <= '0;
      end else if (s2_q.parallel) begin
        data_q <= cur_q;
        data_oe_q <= '1;
      end else begin
        data_q <= {{(`DATA_W - 1){1'b0}}, cur_q[3'h7 - bit_q]};
        data_oe_q <= `DATA_W'(1);
      end
    end
  end

  always_comb begin
    rld_cnt_d = rld_cnt_q;
    if (cfg_evt) begin
      rld_cnt_d = RLD_W'(`RELOAD_PULSE_CYC);
    end else if (rld_cnt_q != '0) begin
      rld_cnt_d = rld_cnt_q - 1'b1;
    end
    rst_cnt_d = rst_cnt_q;
    if (isp_rise) begin
      rst_cnt_d = RST_W'(`ISP_RESET_CYC);
    end else if (rst_cnt_q != '0) begin
      rst_cnt_d = rst_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rld_cnt_q <= '0;
      reload_oe_q <= 1'b0;
    end else if (ce_i) begin
      rld_cnt_q <= rld_cnt_d;
      reload_oe_q <= rld_cnt_d != '0;
    end
  end

  // Own reset holds the open-drain line low
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rst_cnt_q <= '0;
      oe_reset_oe_q <= 1'b1;
      isp_done_q <= 1'b0;
    end else if (ce_i) begin
      rst_cnt_q <= rst_cnt_d;
      oe_reset_oe_q <= rst_cnt_d != '0;
      isp_done_q <= s2_q.in_system_programming && (rst_cnt_d == '0);
    end
  end

  assign data_o = data_q;
  assign data_oe_o = data_oe_q;
  assign chain_enable_out_n_o = chain_n_q;
  assign fpga_reload_request_n_o = 1'b0;
  assign fpga_reload_request_n_oe_o = reload_oe_q;
  assign oe_reset_o = 1'b0;
  assign oe_reset_oe_o = oe_reset_oe_q;
  assign fetch_restart_o = restart_q;

  // ---------------- Test clock domain ----------------
  config_prom_pkg::tap_state_t state_q, state_d;
  config_prom_pkg::dr_sel_t dr_sel;
  logic rst_t1_q, rst_t2_q, tck_rst_n;
  logic [1:0] t1_q, t2_q;
  logic [`IR_WIDTH-1:0] ir_sh_q, ir_q;
  logic [31:0] dr_sh_q;
  logic tdo_q, tdo_oe_q;

  // Reset synchroniser; it needs test clock edges while reset is held
  always_ff @(posedge tck_i) begin
    rst_t1_q <= resetn_i;
    rst_t2_q <= rst_t1_q;
  end
  assign tck_rst_n = rst_t2_q;

  always_ff @(posedge tck_i) begin
    if (!tck_rst_n) begin
      t1_q <= '0;
      t2_q <= '0;
    end else begin
      t1_q <= {isp_done_q, read_secure_i};
      t2_q <= t1_q;
    end
  end

  always_comb begin
    unique case (state_q)
      config_prom_pkg::st_tlr: state_d = tms_i ? config_prom_pkg::st_tlr : config_prom_pkg::st_rti;
      config_prom_pkg::st_rti: state_d = tms_i ? config_prom_pkg::st_sel_dr : config_prom_pkg::st_rti;
      config_prom_pkg::st_sel_dr: state_d = tms_i ? config_prom_pkg::st_sel_ir : config_prom_pkg::st_cap_dr;
      config_prom_pkg::st_cap_dr: state_d = tms_i ? config_prom_pkg::st_ex1_dr : config_prom_pkg::st_sh_dr;
      config_prom_pkg::st_sh_dr: state_d = tms_i ? config_prom_pkg::st_ex1_dr : config_prom_pkg::st_sh_dr;
      config_prom_pkg::st_ex1_dr: state_d = tms_i ? config_prom_pkg::st_upd_dr : config_prom_pkg::st_pa_dr;
      config_prom_pkg::st_pa_dr: state_d = tms_i ? config_prom_pkg::st_ex2_dr : config_prom_pkg::st_pa_dr;
      config_prom_pkg::st_ex2_dr: state_d = tms_i ? config_prom_pkg::st_upd_dr : config_prom_pkg::st_sh_dr;
      config_prom_pkg::st_upd_dr: state_d = tms_i ? config_prom_pkg::st_sel_dr : config_prom_pkg::st_rti;
      config_prom_pkg::st_sel_ir: state_d = tms_i ? config_prom_pkg::st_tlr : config_prom_pkg::st_cap_ir;
      config_prom_pkg::st_cap_ir: state_d = tms_i ? config_prom_pkg::st_ex1_ir : config_prom_pkg::st_sh_ir;
      config_prom_pkg::st_sh_ir: state_d = tms_i ? config_prom_pkg::st_ex1_ir : config_prom_pkg::st_sh_ir;
      config_prom_pkg::st_ex1_ir: state_d = tms_i ? config_prom_pkg::st_upd_ir : config_prom_pkg::st_pa_ir;
      config_prom_pkg::st_pa_ir: state_d = tms_i ? config_prom_pkg::st_ex2_ir : config_prom_pkg::st_pa_ir;
      config_prom_pkg::st_ex2_ir: state_d = tms_i ? config_prom_pkg::st_upd_ir : config_prom_pkg::st_sh_ir;
      config_prom_pkg::st_upd_ir: state_d = tms_i ? config_prom_pkg::st_sel_dr : config_prom_pkg::st_rti;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (!tck_rst_n) begin
      state_q <= config_prom_pkg::st_tlr;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge tck_i) begin
    if (!tck_rst_n || state_q == config_prom_pkg::st_tlr) begin
      ir_sh_q <= '0;
      ir_q <= `IR_IDCODE;
      isp_tq <= 1'b0;
      highz_tq <= 1'b0;
      clamp_tq <= 1'b0;
      if (!tck_rst_n) begin
        cfg_tgl_tq <= 1'b0;
      end
    end else begin
      unique case (state_q)
        config_prom_pkg::st_cap_ir: begin
          ir_sh_q <= `IR_CAPTURE_FIXED;
          ir_sh_q[`IR_ISP_BIT] <= isp_tq && t2_q[1];
          ir_sh_q[`IR_SEC_BIT] <= t2_q[0];
        end
        config_prom_pkg::st_sh_ir: ir_sh_q <= {tdi_i, ir_sh_q[`IR_WIDTH-1:1]};
        config_prom_pkg::st_upd_ir: begin
          ir_q <= ir_sh_q;
          highz_tq <= ir_sh_q == `IR_HIGHZ;
          clamp_tq <= (ir_sh_q == `IR_CLAMP) || (ir_sh_q == `IR_EXTEST);
          if (ir_sh_q == `IR_ISP_ENTER) begin
            isp_tq <= 1'b1;
          end else if (ir_sh_q == `IR_ISP_EXIT) begin
            isp_tq <= 1'b0;
          end
          if (ir_sh_q == `IR_CONFIG) begin
            cfg_tgl_tq <= !cfg_tgl_tq;
          end
        end
        default: ir_sh_q <= ir_sh_q;
      endcase
    end
  end

  always_comb begin
    unique case (ir_q)
      `IR_IDCODE: dr_sel = config_prom_pkg::sel_id;
      `IR_USERCODE: dr_sel = config_prom_pkg::sel_user;
      `IR_EXTEST, `IR_SAMPLE: dr_sel = config_prom_pkg::sel_bsr;
      default: dr_sel = config_prom_pkg::sel_bypass;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (!tck_rst_n) begin
      dr_sh_q <= '0;
      bsr_upd_tq <= '0;
      upd_tgl_tq <= 1'b0;
    end else if (state_q == config_prom_pkg::st_cap_dr) begin
      unique case (dr_sel)
        config_prom_pkg::sel_id: dr_sh_q <= IDCODE_VALUE;
        config_prom_pkg::sel_user: dr_sh_q <= USERCODE_VALUE;
        config_prom_pkg::sel_bsr: dr_sh_q <= {16'h0000, bsr_upd_tq};
        config_prom_pkg::sel_bypass: dr_sh_q <= '0;
      endcase
    end else if (state_q == config_prom_pkg::st_sh_dr) begin
      unique case (dr_sel)
        config_prom_pkg::sel_bypass: dr_sh_q[0] <= tdi_i;
        config_prom_pkg::sel_bsr: dr_sh_q[`BSR_WIDTH-1:0] <= {tdi_i, dr_sh_q[`BSR_WIDTH-1:1]};
        config_prom_pkg::sel_id, config_prom_pkg::sel_user: dr_sh_q <= {tdi_i, dr_sh_q[31:1]};
      endcase
    end else if (state_q == config_prom_pkg::st_upd_dr && dr_sel == config_prom_pkg::sel_bsr) begin
      bsr_upd_tq <= dr_sh_q[`BSR_WIDTH-1:0];
      upd_tgl_tq <= !upd_tgl_tq;
    end
  end

  // Output changes on the falling edge so the host samples it safely
  always_ff @(negedge tck_i) begin
    if (!tck_rst_n) begin
      tdo_q <= 1'b1;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= (state_q == config_prom_pkg::st_sh_ir) ? ir_sh_q[0] : dr_sh_q[0];
      tdo_oe_q <= (state_q == config_prom_pkg::st_sh_ir) || (state_q == config_prom_pkg::st_sh_dr);
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;

  // ---------------- Assertions ----------------
  property p_reload_pulse;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      $rose(reload_oe_q) |-> reload_oe_q[*8] ##[RLD_REST:RLD_REST] !reload_oe_q;
  endproperty
  a_reload_pulse: assert property (p_reload_pulse) else $error("reload pulse width wrong");

  property p_chain_low;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      !chain_n_q |-> $past(!s2_q.ce_n && s2_q.oe_reset && past_tc_q);
  endproperty
  a_chain_low: assert property (p_chain_low) else $error("chain enable low without cause");

  property p_chain_reset;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      !s2_q.oe_reset |=> chain_n_q;
  endproperty
  a_chain_reset: assert property (p_chain_reset) else $error("chain enable low in reset");

  property p_tms_reset;
    @(posedge tck_i) disable iff (!tck_rst_n)
      tms_i[*5] |=> state_q == config_prom_pkg::st_tlr;
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("five mode-select highs missed reset");

  property p_ir_shift;
    @(posedge tck_i) disable iff (!tck_rst_n)
      state_q == config_prom_pkg::st_sh_ir |=> ir_sh_q[`IR_WIDTH-1] == $past(tdi_i);
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("instruction shift lost input");

  property p_tdo_sel;
    @(posedge tck_i) disable iff (!tck_rst_n)
      state_q == config_prom_pkg::st_sh_ir |-> tdo_oe_q && (tdo_q == ir_sh_q[0]);
  endproperty
  a_tdo_sel: assert property (p_tdo_sel) else $error("test output not from instruction");

  property p_bypass;
    @(posedge tck_i) disable iff (!tck_rst_n)
      (state_q == config_prom_pkg::st_sh_dr && ir_q == `IR_BYPASS)
        |=> dr_sh_q[0] == $past(tdi_i);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass stage broken");

  property p_isp_float;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      (s2_q.in_system_programming && !s2_q.clamp) |=> data_oe_q == '0;
  endproperty
  a_isp_float: assert property (p_isp_float) else $error("data driven while programming");

  property p_isp_reset;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      isp_rise |=> (oe_reset_oe_q && !isp_done_q)[*8];
  endproperty
  a_isp_reset: assert property (p_isp_reset) else $error("programming reset not driven");

  property p_count;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      (step && addr_q != tc && active) |=> addr_q == $past(addr_q) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("address counter did not advance");

  property p_clear;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      (!active && !s2_q.clamp) |=> (addr_q == '0) && (data_oe_q == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("counter or outputs not cleared");

  property p_serial_lane;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      (active && !s2_q.parallel && !past_tc_q && !s2_q.in_system_programming && !s2_q.highz && !s2_q.clamp)
        |=> data_oe_q == `DATA_W'(1);
  endproperty
  a_serial_lane: assert property (p_serial_lane) else $error("serial mode lane wrong");

  property p_past_tc;
    @(posedge clk_sys_i) disable iff (!resetn_i || !ce_i)
      (past_tc_q && !s2_q.clamp) |=> data_oe_q == '0;
  endproperty
  a_past_tc: assert property (p_past_tc) else $error("data driven past last address");
endmodule

// ---- include/config_prom_defs.svh ----
`ifndef CONFIG_PROM_DEFS_SVH
`define CONFIG_PROM_DEFS_SVH
// Summary of operation
// - Configuration-restart instruction pulses the open-drain reload request low.
// - Chain enable low only with select low, reset high, counter past last address.
// - Reset line low forces chain enable high; it stays high until the counter passes its last address again.
// - Mode select is sampled on each rising test clock edge to steer the controller.
// - Controller and test registers run on the test clock; the programming reset pulse and output gating run on the system clock.
// - Test data input shifts into the selected instruction or data register.
// - Test data output presents the serial end of the selected register.
// - During programming outputs stay high impedance or at clamp level.
// - Entering programming drives the reset line low before programming proceeds.
// - Device works alone or chained; each device selects the next through its chain enable output.
// - Rising configuration clock advances the counter only with select low, reset high.
// - Reset line low clears counter, floats data unless clamp is set; own reset pulls the line low.
// - Select high clears the counter and floats the data outputs unless clamp is set.
// - Serial mode uses data output zero; parallel mode uses all eight outputs.

`define DATA_W 8
`define BSR_WIDTH 16
`define IR_WIDTH 8
`define IR_EXTEST 8'h00
`define IR_SAMPLE 8'h01
`define IR_BYPASS 8'hff
`define IR_CLAMP 8'hfa
`define IR_HIGHZ 8'hfc
`define IR_IDCODE 8'hfe
`define IR_USERCODE 8'hfd
`define IR_CONFIG 8'hee
`define IR_ISP_ENTER 8'he8
`define IR_ISP_EXIT 8'hf0
`define IR_CAPTURE_FIXED 8'h01
`define IR_ISP_BIT 4
`define IR_SEC_BIT 3
`define IDCODE_DEFAULT 32'h0a5a_5001
`define USERCODE_BLANK 32'hffff_ffff
`define CAPACITY_BITS 4194304
`define CLK_SYS_PERIOD_NS 50
`define RELOAD_PULSE_NS 1000
`define RELOAD_PULSE_CYC ((`RELOAD_PULSE_NS + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)
`define ISP_RESET_NS 1000
`define ISP_RESET_CYC ((`ISP_RESET_NS + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)

`endif

// ---- include/config_prom_pkg.sv ----
package config_prom_pkg;

  typedef enum logic [3:0] {
    st_tlr = 4'h0,
    st_rti = 4'h1,
    st_sel_dr = 4'h2,
    st_cap_dr = 4'h3,
    st_sh_dr = 4'h4,
    st_ex1_dr = 4'h5,
    st_pa_dr = 4'h6,
    st_ex2_dr = 4'h7,
    st_upd_dr = 4'h8,
    st_sel_ir = 4'h9,
    st_cap_ir = 4'ha,
    st_sh_ir = 4'hb,
    st_ex1_ir = 4'hc,
    st_pa_ir = 4'hd,
    st_ex2_ir = 4'he,
    st_upd_ir = 4'hf
  } tap_state_t;

  typedef enum logic [1:0] {
    sel_bypass = 2'h0,
    sel_id = 2'h1,
    sel_user = 2'h2,
    sel_bsr = 2'h3
  } dr_sel_t;

  // Everything that enters the system clock domain from pins or the test clock, except the scan vector
  typedef struct packed {
    logic cclk;
    logic ce_n;
    logic oe_reset;
    logic parallel;
    logic in_system_programming;
    logic highz;
    logic clamp;
    logic upd_tgl;
    logic cfg_tgl;
  } sys_sync_t;

endpackage

// ---- hw/two_entry_buffer.sv ----
`timescale 1ns/1ps

module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic flush_i,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, rd_q;
  logic [PW:0] cnt_q;
  logic push, pop;

  assign in_ready_o = (cnt_q != FULL_CNT) && !flush_i;
  assign out_valid_o = (cnt_q != '0) && !flush_i;
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o && en_i;
  assign pop = out_valid_o && out_ready_i && en_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (en_i) begin
      if (flush_i) begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        if (push) begin
          wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
          cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule

// ---- dv/cfg_port_model.sv ----
`timescale 1ns/1ps

module cfg_port_model (
  // Clock and device side
  input wire logic clk_sys_i,
  input wire logic oe_reset_oe_i,
  // Configuration pins
  output logic cclk_o,
  output logic ce_n_o,
  output logic oe_reset_o
);
  logic hold_low_q = 1'b0;

  // Pull-up on the shared wire; either party may pull it low
  assign oe_reset_o = !(oe_reset_oe_i || hold_low_q);

  initial begin
    cclk_o = 1'b0;
    ce_n_o = 1'b1;
  end

  // Both phases span several system clocks to cover the pin sync latency
  task automatic step();
    @(posedge clk_sys_i) cclk_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    cclk_o <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic select(input logic en);
    @(posedge clk_sys_i) ce_n_o <= !en;
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic hold_reset(input logic low);
    @(posedge clk_sys_i) hold_low_q <= low;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic tck_i = 1'b0;
  logic tms_i = 1'b1;
  logic tdi_i = 1'b1;
  logic par_q = 1'b0;
  logic [1:0] idx_q = 2'h0;
  logic ce_q = 1'b1;
  logic sec_q = 1'b0;
  logic cclk, ce_n, oe_w, oe_oe, src_ready, restart, tdo, rl_oe, chain_n;
  logic tdo_oe, rl_n, oe_drv;
  logic [7:0] data, data_oe;
  logic [7:0] bytes [4] = '{8'ha5, 8'h3c, 8'h00, 8'h00};
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  cfg_port_model fpga (.clk_sys_i(clk_sys_i), .oe_reset_oe_i(oe_oe), .cclk_o(cclk),
    .ce_n_o(ce_n), .oe_reset_o(oe_w));

  config_prom_cascade_jtag_ctrl #(.SERIAL_LAST(15), .PARALLEL_LAST(1)) uut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_q), .cclk_i(cclk), .ce_n_i(ce_n),
    .parallel_mode_i(par_q), .oe_reset_i(oe_w), .oe_reset_o(oe_drv), .oe_reset_oe_o(oe_oe),
    .data_o(data), .data_oe_o(data_oe), .chain_enable_out_n_o(chain_n),
    .fpga_reload_request_n_o(rl_n), .fpga_reload_request_n_oe_o(rl_oe), .tck_i(tck_i),
    .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .read_secure_i(sec_q),
    .src_data_i(bytes[idx_q]), .src_valid_i(1'b1), .src_ready_o(src_ready),
    .fetch_restart_o(restart));

  // Source restarts from byte zero whenever the counter is cleared
  always @(posedge clk_sys_i) begin
    if (restart)
      idx_q <= 2'h0;
    else if (src_ready && idx_q != 2'h3)
      idx_q <= idx_q + 2'h1;
  end

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Test clock only runs inside tck_cyc calls; output sampled while the clock is low
  task automatic tck_cyc(input logic m, input logic d, output logic q);
    tms_i = m;
    tdi_i = d;
    #16 q = tdo;
    tck_i = 1'b1;
    #16 tck_i = 1'b0;
  endtask

  task automatic ir_scan(input logic [7:0] code, output logic [7:0] cap);
    logic q;
    tck_cyc(1'b1, 1'b1, q);
    tck_cyc(1'b1, 1'b1, q);
    tck_cyc(1'b0, 1'b1, q);
    tck_cyc(1'b0, 1'b1, q);
    // Output enable moves on the falling edge, so look just after it
    for (int i = 0; i < 8; i++) begin
      #1 check("tdo oe", tdo_oe, 1'b1);
      tck_cyc(i == 7, code[i], cap[i]);
    end
    tck_cyc(1'b1, 1'b1, q);
    tck_cyc(1'b0, 1'b1, q);
    #1 check("tdo idle", tdo_oe, 1'b0);
  endtask

  // One-stage bypass path delays test data by a single clock
  task automatic bypass_scan();
    logic [7:0] cap;
    logic q0, q1;
    ir_scan(8'hff, cap);
    tck_cyc(1'b1, 1'b1, q0);
    tck_cyc(1'b0, 1'b1, q0);
    tck_cyc(1'b0, 1'b1, q0);
    tck_cyc(1'b0, 1'b1, q0);
    tck_cyc(1'b1, 1'b0, q1);
    check("bypass", {q0, q1}, 2'b01);
    tck_cyc(1'b1, 1'b1, q0);
    tck_cyc(1'b0, 1'b1, q0);
  endtask

  task automatic count_high(input logic in_system_programming, output int n);
    n = 0;
    repeat (60) @(posedge clk_sys_i) n += in_system_programming ? oe_oe : rl_oe;
  endtask

  // Leaves the device past its last address, still selected
  task automatic run_stream(input logic par, input int last);
    @(posedge clk_sys_i) par_q <= par;
    fpga.select(1'b1);
    for (int a = 0; a <= last; a++) begin
      if (par)
        check("data", data, bytes[a]);
      else
        check("bit", data[0], bytes[a / 8][7 - a % 8]);
      check("oe", data_oe, par ? 8'hff : 8'h01);
      check("chain", chain_n, 1'b1);
      fpga.step();
    end
    check("past oe", data_oe, 8'h00);
    check("past chain", chain_n, 1'b0);
  endtask

  initial begin
    logic [7:0] cap;
    int n;
    fork
      repeat (16) @(posedge clk_sys_i);
      repeat (5) tck_cyc(1'b1, 1'b1, cap[0]);
    join
    check("rst pull", oe_oe, 1'b1);
    check("rst chain", chain_n, 1'b1);
    check("od lvl", {oe_drv, rl_n}, 2'b00);
    @(posedge clk_sys_i) resetn_i <= 1'b1;
    repeat (3) tck_cyc(1'b1, 1'b1, cap[0]);
    tck_cyc(1'b0, 1'b1, cap[0]);
    run_stream(1'b0, 15);
    fpga.hold_reset(1'b1);
    check("hold oe", data_oe, 8'h00);
    check("hold chain", chain_n, 1'b1);
    fpga.hold_reset(1'b0);
    check("rel chain", chain_n, 1'b1);
    check("rel bit", data[0], 1'b1);
    fpga.select(1'b0);
    check("idle oe", data_oe, 8'h00);
    check("idle chain", chain_n, 1'b1);
    run_stream(1'b1, 1);
    // Clock enable low must freeze the chain output despite the reset line
    @(posedge clk_sys_i) ce_q <= 1'b0;
    fpga.hold_reset(1'b1);
    check("frozen chain", chain_n, 1'b0);
    @(posedge clk_sys_i) ce_q <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check("thaw chain", chain_n, 1'b1);
    fpga.hold_reset(1'b0);
    check("run oe", data_oe, 8'hff);
    ir_scan(8'hfc, cap);
    repeat (4) @(posedge clk_sys_i);
    check("highz oe", data_oe, 8'h00);
    ir_scan(8'hee, cap);
    check("ir cap", cap, 8'h01);
    count_high(1'b0, n);
    check("reload len", n, 32'h14);
    ir_scan(8'he8, cap);
    count_high(1'b1, n);
    check("isp reset len", n, 32'h14);
    check("isp oe", data_oe, 8'h00);
    check("isp chain", chain_n, 1'b1);
    @(posedge clk_sys_i) sec_q <= 1'b1;
    ir_scan(8'hf0, cap);
    check("isp cap", cap, 8'h19);
    bypass_scan();
    finish_test();
  end
endmodule
